// *** rtl/psis_crc8.sv ***
/*
  Bit-serial CRC-8 over received result bits.
  Assumes bits arrive msb first, one per enable pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module psis_crc8
  import psis_pkg::*;
(
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_nrst,
  // bit stream
  psis_crc_if.calc    bus
);

  logic [7:0] crc_r;
  logic       fb_w;
  logic [7:0] crc_nxt;

  // ==========================================================
  // shift with feedback, no reflection and no final inversion
  assign fb_w    = crc_r[7] ^ bus.bit_in;
  assign crc_nxt = {crc_r[6:0], 1'h0} ^ (fb_w ? CRC_POLY : 8'h00);
  assign bus.crc = crc_r;

  always_ff @(posedge i_clk) begin
    if (!i_nrst || bus.clr) begin
      crc_r <= CRC_INIT;
    end else if (bus.en) begin
      crc_r <= crc_nxt;
    end
  end

endmodule
`default_nettype wire

// *** rtl/psis_crc_if.sv ***
/*
  Carrier between the bus master and its checksum unit.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface psis_crc_if;
  logic       clr;
  logic       en;
  logic       bit_in;
  logic [7:0] crc;
  modport calc (input clr, input en, input bit_in, output crc);
  modport user (output clr, output en, output bit_in, input crc);
endinterface
`default_nettype wire

// *** rtl/psis_master.sv ***
/*
  Bus master that triggers and reads one differential pressure result.
  Assumes external pull-ups on scl and sda and a slave that may stretch.
*/
// Operation
// - header is address then direction bit, 0 write, 1 read.
// - read header for the default address is hex 81.
// - master makes START; bus busy from then on.
// - master makes STOP; bus free afterwards.
// - receiver pulls sda low in the ninth bit to acknowledge.
// - sda released in the ninth bit means not-acknowledge.
// - master waits for scl high before clocking on.
// - bytes are eight bits, msb first, each followed by acknowledge.
// - every sequence opens with START and a header byte.
// - direction 0 keeps master to slave; 1 turns after header.
// - scl runs at 100 kHz typical, never above 400 kHz.
// - lines are only pulled low or released, never driven high.
// - command F1 arms; following read header starts the conversion.
`timescale 1ns/1ps
`default_nettype none
module psis_master
  import psis_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR      = DEV_ADDR_DFLT,
  parameter int unsigned QTR_CYC_P     = QTR_CYC,
  parameter int unsigned STRETCH_CYC_P = STRETCH_CYC
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // request
  input  wire logic        i_start,
  input  wire logic        i_crc_en,
  // result
  output logic             o_busy,
  output logic             o_done,
  output logic             o_err,
  output logic [15:0]      o_data,
  output logic [7:0]       o_crc,
  output logic             o_crc_ok,
  // bus pins
  input  wire logic        i_scl,
  output logic             o_scl_o,
  output logic             o_scl_oe,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe
);

  localparam int DW = $clog2(QTR_CYC_P + 1);
  localparam int TW = $clog2(STRETCH_CYC_P + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(QTR_CYC_P - 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(STRETCH_CYC_P - 1);

  psis_state_e state_r;
  logic [DW-1:0] div_r;
  logic [TW-1:0] tmo_r;
  logic          tick_r;
  logic [1:0]    ph_r;
  logic [2:0]    bit_r;
  logic [2:0]    seq_r;
  logic [7:0]    sh_r;
  logic          nack_r;
  logic          crc_en_r;
  logic          scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  logic          busy_r, done_r, err_r, crc_ok_r;
  logic [15:0]   data_r;
  logic [7:0]    crc_rx_r;
  logic          scl_oe_r, sda_oe_r, zero_r;

  psis_crc_if crc_bus ();

  psis_crc8 u_crc (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .bus    (crc_bus.calc)
  );

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      scl_m_r <= 1'h1;
      scl_s_r <= 1'h1;
      sda_m_r <= 1'h1;
      sda_s_r <= 1'h1;
    end else begin
      scl_m_r <= i_scl;
      scl_s_r <= scl_m_r;
      sda_m_r <= i_sda;
      sda_s_r <= sda_m_r;
    end
  end

  // ==========================================================
  // quarter-bit enable; 100 kHz keeps us under the 400 kHz ceiling
  always_ff @(posedge i_clk) begin
    if (!i_nrst || div_r == DIV_LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tick_r <= 1'h0;
    end else begin
      tick_r <= (div_r == DIV_LAST);
    end
  end

  // ==========================================================
  // decode
  wire active_w = (state_r != PSIS_IDLE) && (state_r != PSIS_DONE);
  // slave still holds scl low after we released it
  wire stall_w  = active_w && (ph_r == PH_HIGH) && !scl_oe_r &&
                  !scl_s_r;
  wire adv_w    = tick_r && !stall_w;
  wire tmo_w    = stall_w && (tmo_r == TMO_LAST);
  wire is_rx_w  = (seq_r >= SEQ_DATA_HI);
  wire ack_w    = (seq_r == SEQ_DATA_HI) ||
                  ((seq_r == SEQ_DATA_LO) && crc_en_r);
  wire [7:0] tx_byte_w =
    (seq_r == SEQ_ADDR_WR) ? {DEV_ADDR, DIR_WR} :
    (seq_r == SEQ_CMD)     ? CMD_TRIG :
                             {DEV_ADDR, DIR_RD};
  wire to_stop_w = nack_r || (seq_r == SEQ_CMD) ||
                   (is_rx_w && !ack_w);
  wire last_ph_w = adv_w && (ph_r == PH_FALL);

  assign crc_bus.clr    = (state_r == PSIS_IDLE) && i_start;
  assign crc_bus.en     = adv_w && (state_r == PSIS_BIT) &&
                          (ph_r == PH_HIGH) &&
                          ((seq_r == SEQ_DATA_HI) ||
                           (seq_r == SEQ_DATA_LO));
  assign crc_bus.bit_in = sda_s_r;

  // hold timeout keeps a dead slave from hanging the master
  always_ff @(posedge i_clk) begin
    if (!i_nrst || !stall_w) begin
      tmo_r <= '0;
    end else begin
      tmo_r <= tmo_r + TW'(1);
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r  <= PSIS_IDLE;
      ph_r     <= PH_DATA;
      bit_r    <= BIT_MSB;
      seq_r    <= SEQ_ADDR_WR;
      sh_r     <= 8'h00;
      nack_r   <= 1'h0;
      crc_en_r <= 1'h0;
      busy_r   <= 1'h0;
      done_r   <= 1'h0;
      err_r    <= 1'h0;
      crc_ok_r <= 1'h0;
      data_r   <= 16'h0000;
      crc_rx_r <= 8'h00;
      scl_oe_r <= 1'h0;
      sda_oe_r <= 1'h0;
      zero_r   <= 1'h0;
    end else begin
      done_r <= 1'h0;
      if (tmo_w) begin
        scl_oe_r <= 1'h0;
        sda_oe_r <= 1'h0;
        err_r    <= 1'h1;
        state_r  <= PSIS_DONE;
      end else if (state_r == PSIS_IDLE) begin
        if (i_start) begin
          busy_r   <= 1'h1;
          err_r    <= 1'h0;
          nack_r   <= 1'h0;
          crc_en_r <= i_crc_en;
          seq_r    <= SEQ_ADDR_WR;
          ph_r     <= PH_DATA;
          state_r  <= PSIS_START;
        end
      end else if (state_r == PSIS_DONE) begin
        done_r   <= 1'h1;
        busy_r   <= 1'h0;
        crc_ok_r <= (crc_rx_r == crc_bus.crc);
        state_r  <= PSIS_IDLE;
      end else if (adv_w) begin
        ph_r <= ph_r + 2'h1;
        case (state_r)
          PSIS_START: begin
            if (ph_r == PH_DATA) begin
              sda_oe_r <= 1'h0;
              scl_oe_r <= 1'h0;
            end else if (ph_r == PH_HIGH) begin
              sda_oe_r <= 1'h1;
            end else if (ph_r == PH_FALL) begin
              scl_oe_r <= 1'h1;
              bit_r    <= BIT_MSB;
              state_r  <= PSIS_BIT;
            end
          end
          PSIS_BIT: begin
            if (ph_r == PH_DATA) begin
              sda_oe_r <= !is_rx_w && !tx_byte_w[bit_r];
            end else if (ph_r == PH_RISE) begin
              scl_oe_r <= 1'h0;
            end else if (ph_r == PH_HIGH) begin
              sh_r <= {sh_r[6:0], sda_s_r};
            end else begin
              scl_oe_r <= 1'h1;
              bit_r    <= bit_r - 3'h1;
              if (bit_r == 3'h0) begin
                state_r <= PSIS_ACK;
              end
            end
          end
          PSIS_ACK: begin
            if (ph_r == PH_DATA) begin
              sda_oe_r <= is_rx_w && ack_w;
            end else if (ph_r == PH_RISE) begin
              scl_oe_r <= 1'h0;
            end else if (ph_r == PH_HIGH) begin
              nack_r <= !is_rx_w && sda_s_r;
              if (seq_r == SEQ_DATA_HI) data_r[15:8] <= sh_r;
              if (seq_r == SEQ_DATA_LO) data_r[7:0]  <= sh_r;
              if (seq_r == SEQ_CRC)     crc_rx_r     <= sh_r;
            end else begin
              scl_oe_r <= 1'h1;
              bit_r    <= BIT_MSB;
              if (to_stop_w) begin
                err_r   <= nack_r;
                state_r <= PSIS_STOP;
              end else begin
                seq_r   <= seq_r + 3'h1;
                state_r <= PSIS_BIT;
              end
            end
          end
          PSIS_STOP: begin
            if (ph_r == PH_DATA) begin
              sda_oe_r <= 1'h1;
            end else if (ph_r == PH_RISE) begin
              scl_oe_r <= 1'h0;
            end else if (ph_r == PH_HIGH) begin
              sda_oe_r <= 1'h0;
            end else if (seq_r == SEQ_CMD && !err_r) begin
              seq_r   <= SEQ_ADDR_RD;
              state_r <= PSIS_START;
            end else begin
              state_r <= PSIS_DONE;
            end
          end
          default: begin
            state_r <= PSIS_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // outputs; pin data is a constant low so lines are never driven high
  assign o_busy   = busy_r;
  assign o_done   = done_r;
  assign o_err    = err_r;
  assign o_data   = data_r;
  assign o_crc    = crc_rx_r;
  assign o_crc_ok = crc_ok_r;
  assign o_scl_o  = zero_r;
  assign o_sda_o  = zero_r;
  assign o_scl_oe = scl_oe_r;
  assign o_sda_oe = sda_oe_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_scl_hold_wait: assert property (stall_w && !tmo_w |=>
    ph_r == PH_HIGH && state_r == $past(state_r))
    else $error("master clocked on while scl held low");
  a_pins_low_only: assert property (!o_scl_o && !o_sda_o)
    else $error("pin data not low");
  a_read_header: assert property (seq_r == SEQ_ADDR_RD |->
    tx_byte_w == {DEV_ADDR, 1'h1})
    else $error("read header wrong");
  a_start_edge: assert property (state_r == PSIS_START && adv_w &&
    ph_r == PH_HIGH |=> sda_oe_r && !scl_oe_r)
    else $error("start not sda fall with scl high");
  a_stop_edge: assert property (state_r == PSIS_STOP && adv_w &&
    ph_r == PH_HIGH |=> !sda_oe_r && !scl_oe_r)
    else $error("stop not sda rise with scl high");
  a_msb_first: assert property (state_r == PSIS_BIT && !is_rx_w &&
    ph_r == PH_RISE |-> sda_oe_r == !tx_byte_w[bit_r])
    else $error("tx bit not msb first");
  a_rx_released: assert property (state_r == PSIS_BIT && is_rx_w &&
    ph_r != PH_DATA |-> !sda_oe_r)
    else $error("master drove sda in read data");
  a_ack_drive: assert property (state_r == PSIS_ACK && ph_r == PH_HIGH
    |-> sda_oe_r == (is_rx_w && ack_w))
    else $error("master acknowledge wrong");
  a_nack_stop: assert property (state_r == PSIS_ACK && last_ph_w &&
    nack_r |=> state_r == PSIS_STOP && err_r)
    else $error("slave nack not ending transfer");
  a_done_free: assert property ($rose(done_r) |->
    !o_scl_oe && !o_sda_oe ##1 !o_busy)
    else $error("bus not free at done");

endmodule
`default_nettype wire

// *** rtl/psis_pkg.sv ***
/*
  Constants and types shared by the pressure sensor bus master.
  Assumes one 200 MHz system clock and an open-drain two-wire bus.
*/
package psis_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned SCL_HZ        = 100_000;
  localparam int unsigned SCL_MAX_HZ    = 400_000;
  localparam int unsigned QTR_CYC       = CLK_HZ / (4 * SCL_HZ);
  localparam int unsigned STRETCH_MAX_US = 10_000;
  localparam int unsigned STRETCH_CYC   =
    (CLK_HZ / 1_000_000) * STRETCH_MAX_US;

  // ==========================================================
  // header and command
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h40;
  localparam logic       DIR_WR        = 1'h0;
  localparam logic       DIR_RD        = 1'h1;
  localparam logic [7:0] CMD_TRIG      = 8'hF1;
  localparam logic [2:0] BIT_MSB       = 3'h7;

  // ==========================================================
  // checksum
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // ==========================================================
  // byte order of one measurement
  localparam logic [2:0] SEQ_ADDR_WR = 3'h0;
  localparam logic [2:0] SEQ_CMD     = 3'h1;
  localparam logic [2:0] SEQ_ADDR_RD = 3'h2;
  localparam logic [2:0] SEQ_DATA_HI = 3'h3;
  localparam logic [2:0] SEQ_DATA_LO = 3'h4;
  localparam logic [2:0] SEQ_CRC     = 3'h5;

  // ==========================================================
  // bit phases within one scl period
  localparam logic [1:0] PH_DATA = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  typedef enum logic [2:0] {
    PSIS_IDLE  = 3'h0,
    PSIS_START = 3'h1,
    PSIS_BIT   = 3'h3,
    PSIS_ACK   = 3'h2,
    PSIS_STOP  = 3'h6,
    PSIS_DONE  = 3'h7
  } psis_state_e;

endpackage

// *** verification/psis_slave_model.sv ***
/*
  Behavioural pressure sensor slave on the two-wire bus.
  Assumes the bench resolves both open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module psis_slave_model (
  // bus lines
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_scl_oe,
  output logic             o_sda_oe,
  // behaviour
  input  wire logic [6:0]  i_addr,
  input  wire logic        i_cmd_ok,
  input  wire logic        i_bad_crc,
  input  wire logic [15:0] i_data,
  input  wire logic [31:0] i_hold_ns
);
  // ==========================================================
  // log of what the master did
  logic [7:0] hdr_wr = 8'h00;
  logic [7:0] hdr_rd = 8'h00;
  logic [7:0] cmd    = 8'h00;
  logic       armed  = 1'b0;
  int         sent   = 0;
  int         starts = 0;
  int         stops  = 0;

  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end

  always @(negedge i_sda) if (i_scl === 1'b1) starts++;
  always @(posedge i_sda) if (i_scl === 1'b1) stops++;

  // ==========================================================
  // checksum
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction

  // ==========================================================
  // bit level
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_scl);
      b[i] = i_sda;
    end
  endtask

  task automatic ack(input logic yes);
    @(negedge i_scl);
    #1 o_sda_oe = yes;
    @(negedge i_scl);
    #1 o_sda_oe = 1'b0;
  endtask

  // entered just after scl fell; leaves sda released on the ack bit
  task automatic put_byte(input logic [7:0] b, output logic acked);
    sent++;
    for (int i = 7; i >= 0; i--) begin
      o_sda_oe = ~b[i];
      @(negedge i_scl);
      #1;
    end
    o_sda_oe = 1'b0;
    @(posedge i_scl);
    acked = ~i_sda;
    @(negedge i_scl);
    #1;
  endtask

  // ==========================================================
  // transfer sequences
  always begin : serve
    logic [7:0] b;
    logic       ok;
    @(negedge i_sda iff i_scl === 1'b1);
    get_byte(b);
    if (b[7:1] == i_addr) begin
      ack(1'b1);
      if (b[0] == 1'b0) begin
        hdr_wr = b;
        get_byte(cmd);
        armed = (cmd == 8'hF1) && i_cmd_ok;
        ack(armed);
      end else begin
        hdr_rd = b;
        // conversion time is a bench setting
        o_scl_oe = armed;
        o_sda_oe = ~i_data[15];
        #(i_hold_ns);
        o_scl_oe = 1'b0;
        put_byte(i_data[15:8], ok);
        if (ok) put_byte(i_data[7:0], ok);
        if (ok) put_byte(crc8(i_data) ^ {7'h00, i_bad_crc}, ok);
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
/*
  Self-checking bench for the pressure sensor bus master.
  Assumes the rtl package and the slave model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  num_checks++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module tb;
  import psis_pkg::*;
  // ==========================================================
  // one measurement: settings, then expected outcome
  typedef struct {
    logic        crc_en;
    logic [6:0]  addr;
    logic        cmd_ok;
    logic        bad_crc;
    logic [15:0] data;
    int          hold_ns;
    logic        err;
    logic        crc_ok;
    int          sent;
    int          nst;
    int          nsp;
  } psis_row_s;

  logic        clk     = 1'b0;
  logic        nrst    = 1'b0;
  logic        start   = 1'b0;
  logic        crc_en  = 1'b0;
  logic        busy, done, err, crc_ok;
  logic [15:0] data;
  logic [7:0]  crc;
  logic        m_scl_o, m_scl_oe, m_sda_o, m_sda_oe;
  logic        s_scl_oe, s_sda_oe;
  logic [6:0]  addr    = 7'h40;
  logic        cmd_ok  = 1'b1;
  logic        bad_crc = 1'b0;
  logic [15:0] s_data  = 16'h0000;
  logic [31:0] hold_ns = 32'h0;
  wire logic   scl;
  wire logic   sda;
  int          num_errors = 0;
  int          num_checks = 0;
  psis_row_s   rows [6];

  assign scl = ~(m_scl_oe | s_scl_oe);
  assign sda = ~(m_sda_oe | s_sda_oe);
  always #2.5 clk = ~clk;

  psis_master #(
    .QTR_CYC_P     (8),
    .STRETCH_CYC_P (2000)
  ) u_psis_master (
    .i_clk    (clk),
    .i_nrst   (nrst),
    .i_start  (start),
    .i_crc_en (crc_en),
    .o_busy   (busy),
    .o_done   (done),
    .o_err    (err),
    .o_data   (data),
    .o_crc    (crc),
    .o_crc_ok (crc_ok),
    .i_scl    (scl),
    .o_scl_o  (m_scl_o),
    .o_scl_oe (m_scl_oe),
    .i_sda    (sda),
    .o_sda_o  (m_sda_o),
    .o_sda_oe (m_sda_oe)
  );

  psis_slave_model u_psis_slave_model (
    .i_scl     (scl),
    .i_sda     (sda),
    .o_scl_oe  (s_scl_oe),
    .o_sda_oe  (s_sda_oe),
    .i_addr    (addr),
    .i_cmd_ok  (cmd_ok),
    .i_bad_crc (bad_crc),
    .i_data    (s_data),
    .i_hold_ns (hold_ns)
  );

  // ==========================================================
  // tasks
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic run(input psis_row_s r);
    int n;
    int s0;
    int p0;
    int t0;
    n       = 0;
    s0      = u_psis_slave_model.starts;
    p0      = u_psis_slave_model.stops;
    t0      = u_psis_slave_model.sent;
    addr    = r.addr;
    cmd_ok  = r.cmd_ok;
    bad_crc = r.bad_crc;
    s_data  = r.data;
    hold_ns = r.hold_ns;
    crc_en  = r.crc_en;
    start   = 1'b1;
    tick();
    start = 1'b0;
    tick();
    `CHK(busy, 1'b1)
    // a second request while busy must be ignored
    start = 1'b1;
    tick();
    start = 1'b0;
    while (done !== 1'b1 && n < 20000) begin
      tick();
      n++;
    end
    if (n >= 20000) begin
      num_errors++;
      results();
    end
    `CHK(err, r.err)
    `CHK(u_psis_slave_model.starts - s0, r.nst)
    `CHK(u_psis_slave_model.stops - p0, r.nsp)
    `CHK(u_psis_slave_model.sent - t0, r.sent)
    `CHK({m_scl_o, m_sda_o}, 2'h0)
    if (r.err === 1'b0) begin
      `CHK(u_psis_slave_model.hdr_wr, 8'h80)
      `CHK(u_psis_slave_model.hdr_rd, 8'h81)
      `CHK(u_psis_slave_model.cmd, 8'hF1)
      `CHK(data, r.data)
    end
    if (r.crc_en === 1'b1 && r.err === 1'b0) begin
      `CHK(crc, u_psis_slave_model.crc8(r.data) ^ {7'h00, r.bad_crc})
      `CHK(crc_ok, r.crc_ok)
    end
    tick();
    `CHK(done, 1'b0)
    repeat (3) tick();
    `CHK(busy, 1'b0)
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rows[0] = '{1'b1, 7'h40, 1'b1, 1'b0, 16'h1234, 500, 1'b0, 1'b1, 3, 2, 2};
    rows[1] = '{1'b0, 7'h40, 1'b1, 1'b0, 16'hFFFF, 0, 1'b0, 1'b0, 2, 2, 2};
    rows[2] = '{1'b1, 7'h40, 1'b1, 1'b1, 16'h0000, 1000, 1'b0, 1'b0, 3, 2, 2};
    rows[3] = '{1'b1, 7'h41, 1'b1, 1'b0, 16'h1234, 0, 1'b1, 1'b0, 0, 1, 1};
    rows[4] = '{1'b1, 7'h40, 1'b0, 1'b0, 16'h1234, 0, 1'b1, 1'b0, 0, 1, 1};
    rows[5] = '{1'b1, 7'h40, 1'b1, 1'b0, 16'h8001, 9000, 1'b0, 1'b1, 3, 2, 2};
    repeat (5) tick();
    `CHK({busy, done, err, m_scl_oe, m_sda_oe}, 5'h00)
    nrst = 1'b1;
    foreach (rows[i]) run(rows[i]);
    // hold past the stretch limit: master gives up without a stop
    run('{1'b1, 7'h40, 1'b1, 1'b0, 16'h5A5A, 12000, 1'b1, 1'b0, 0, 2, 1});
    `CHK({m_scl_oe, m_sda_oe}, 2'h0)
    // reset in mid-transfer must release both lines at once
    start = 1'b1;
    tick();
    start = 1'b0;
    repeat (20) tick();
    `CHK(busy, 1'b1)
    nrst = 1'b0;
    repeat (2) tick();
    `CHK({busy, done, err, m_scl_oe, m_sda_oe}, 5'h00)
    nrst = 1'b1;
    tick();
    `CHK({busy, done, err, m_scl_oe, m_sda_oe}, 5'h00)
    results();
  end
endmodule
`default_nettype wire
